// [bench/pdwc_wake_src.sv]
/*
 * pdwc_wake_src: far side of the wake controller, the reset pin and
 * the latched interrupt flags of the core.
 * assumes bench commands change just after rising edges of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pdwc_wake_src (
    input  wire logic       clk_i,
    input  wire logic       mc_req_i,
    input  wire logic [2:0] irq_set_i,
    input  wire logic       irq_clr_i,
    output logic            mc_pin_n_o,
    output logic [2:0]      irq_flag_o
);
    // pin held high unless a reset is asked for, asleep or not
    assign mc_pin_n_o = ~mc_req_i;
    // flags latch whatever the enables, so a masked source still shows
    always @(posedge clk_i) begin
        irq_flag_o <= irq_clr_i ? 3'h0 : (irq_flag_o | irq_set_i);
    end
    initial irq_flag_o = 3'h0;
endmodule : pdwc_wake_src
`default_nettype wire

// [bench/tb_top.sv]
/*
 * tb_top: self-checking bench of pdwc_top.
 * assumes pdwc_wake_src drives the reset pin and interrupt flags.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [2:0] en;
        logic [2:0] fl;
        logic       g;
        logic       wk;
        logic       vc;
    } pdwc_row_type;
    // en, flag, global enable, wakes, vectors
    pdwc_row_type rows [4] = '{
        '{3'h1, 3'h1, 1'b0, 1'b1, 1'b0},
        '{3'h2, 3'h2, 1'b1, 1'b1, 1'b1},
        '{3'h4, 3'h4, 1'b1, 1'b0, 1'b0},
        '{3'h1, 3'h2, 1'b1, 1'b0, 1'b0}};
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic        awr, wr, bv, arr, rv, osc, crst, pf, res, vec, tstp, dnf, to;
    logic [7:0]  cfg = 8'h03, pout = 8'ha5, poe = 8'h3c, pdo, poo;
    logic        slp = 0, clr = 0, global_irq_enable = 0, mcq = 0, iclr = 0, mc_n;
    logic [2:0]  ien = '0, iset = '0, flg;
    logic        res_seen = 0, vec_seen = 0, rst_seen = 0;
    int          n_mismatch = 0, compares = 0, n;

    always #25 clk_i = ~clk_i;

    pdwc_wake_src u_src (.clk_i(clk_i), .mc_req_i(mcq), .irq_set_i(iset),
        .irq_clr_i(iclr), .mc_pin_n_o(mc_n), .irq_flag_o(flg));

    pdwc_top #(.WDT_CYCLES(20)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .config_word_i(cfg), .master_clear_pin_i(mc_n),
        .sleep_exec_i(slp), .watchdog_clear_instruction_i(clr),
        .irq_flag_i(flg), .irq_en_i(ien), .global_irq_enable_i(global_irq_enable),
        .port_out_i(pout), .port_oe_i(poe), .port_out_o(pdo),
        .port_oe_o(poo), .osc_drive_en_o(osc), .core_reset_o(crst),
        .prefetch_next_o(pf), .resume_o(res), .vector_irq_o(vec),
        .timer_stop_o(tstp), .powered_down_flag_o(dnf),
        .timeout_flag_o(to));

    // one-cycle outputs are caught here so waits cannot miss them
    always @(posedge clk_i) begin
        if (res === 1'b1) begin
            res_seen <= 1'b1;
            vec_seen <= vec;
        end
        if (crst === 1'b1)
            rst_seen <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(posedge clk_i); while (awr !== 1'b1 || wr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bv !== 1'b1) @(posedge clk_i);
        rsp = bresp;
        br <= 1'b0;
        // one idle edge so a following call never re-raises bready at once
        @(posedge clk_i);
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] a);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk_i); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk_i);
        rd = rdata;
        rsp = rresp;
        rr <= 1'b0;
        @(posedge clk_i);
    endtask : axi_rd

    task automatic rst_dut(input logic [7:0] s);
        sys_rst_i <= 1'b1;
        cfg <= s;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : rst_dut

    // sleep pulse, then the first sleeping cycle is sampled
    task automatic enter_sleep;
        res_seen = 1'b0;
        vec_seen = 1'b0;
        slp <= 1'b1;
        @(posedge clk_i);
        chk(pf, 1'b1);
        slp <= 1'b0;
        pout <= 8'h5a;
        poe <= 8'hc3;
        @(posedge clk_i);
        chk({osc, dnf, to, tstp}, 4'h3);
    endtask : enter_sleep

    initial begin
        #(10_000 * 50);
        n_mismatch++;
        print_verdict;
    end

    initial begin
        rst_dut(8'h03);
        axi_rd(pdwc_pkg::STATUS_ADDR);
        chk(rd, 32'h3);
        axi_rd(pdwc_pkg::OPTION_ADDR);
        chk(rd, 32'hff);
        // watchdog strapped off: even a 1:1 postscaler never times out
        rst_seen = 1'b0;
        axi_wr(pdwc_pkg::OPTION_ADDR, 32'h08);
        repeat (100) @(posedge clk_i);
        chk(rst_seen, 1'b0);
        foreach (rows[i]) begin
            ien <= rows[i].en;
            global_irq_enable <= rows[i].g;
            iset <= rows[i].fl;
            pout <= 8'ha5;
            poe <= 8'h3c;
            @(posedge clk_i);
            iset <= 3'h0;
            enter_sleep;
            repeat (10) @(posedge clk_i);
            chk(res_seen, rows[i].wk);
            chk(vec_seen, rows[i].vc);
            chk({pdo, poo}, rows[i].wk ? 16'h5ac3 : 16'ha53c);
            if (!rows[i].wk) begin
                mcq <= 1'b1;
                repeat (5) @(posedge clk_i);
                chk(crst, 1'b1);
                mcq <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
            iclr <= 1'b1;
            @(posedge clk_i);
            iclr <= 1'b0;
        end
        // crystal mode, watchdog on, postscaler 1:64 keeps it off start-up
        rst_dut(8'h04);
        axi_rd(pdwc_pkg::CONFIG_ADDR);
        chk(rd, 32'h4);
        axi_wr(pdwc_pkg::CONFIG_ADDR, 32'h0);
        chk(rsp, pdwc_pkg::RESP_SLVERR);
        axi_rd(16'h0010);
        chk(rsp, pdwc_pkg::RESP_SLVERR);
        axi_wr(pdwc_pkg::OPTION_ADDR, 32'h0e);
        chk(rsp, pdwc_pkg::RESP_OKAY);
        enter_sleep;
        n = 0;
        while (osc !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (res !== 1'b1 && n < 1100);
        chk(n, 1024);
        chk({dnf, to}, 2'h0);
        rst_seen = 1'b0;
        repeat (4) begin
            repeat (100) @(posedge clk_i);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
        end
        chk(rst_seen, 1'b0);
        repeat (1400) @(posedge clk_i);
        chk(rst_seen, 1'b1);
        axi_wr(pdwc_pkg::CONTROL_ADDR, 32'h1);
        axi_rd(pdwc_pkg::STATUS_ADDR);
        chk(rd, 32'h3);
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire

// [hdl/pdwc_pkg.sv]
/*
 * pdwc_pkg: constants and types of the power-down and wake controller.
 * assumes a single 20 MHz core clock and an AXI4-Lite register port.
 */
package pdwc_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;
    // register indices; byte address is four times the index
    localparam int unsigned OPTION_IDX   = 32'h0000_0081;
    localparam int unsigned CONFIG_IDX   = 32'h0000_2007;
    localparam int unsigned STATUS_IDX   = 32'h0000_0100;
    localparam int unsigned CONTROL_IDX  = 32'h0000_0101;
    localparam logic [15:0] OPTION_ADDR  = 16'(OPTION_IDX * 4);
    localparam logic [15:0] CONFIG_ADDR  = 16'(CONFIG_IDX * 4);
    localparam logic [15:0] STATUS_ADDR  = 16'(STATUS_IDX * 4);
    localparam logic [15:0] CONTROL_ADDR = 16'(CONTROL_IDX * 4);
    localparam logic [7:0]  OPTION_RST   = 8'hff;
    localparam int unsigned OPT_POST_SEL = 3;
    localparam int unsigned OPT_PS_LSB   = 0;
    localparam int unsigned CFG_WD_EN    = 2;
    localparam int unsigned CFG_OSC_LSB  = 0;
    localparam logic [1:0]  OSC_MODE_RC  = 2'h3;
    localparam int unsigned ST_DOWN      = 0;
    localparam int unsigned ST_TO        = 1;
    localparam int unsigned ST_ASLEEP    = 2;
    localparam int unsigned CTL_PORST    = 0;
    localparam int unsigned IRQ_PORT     = 0;
    localparam int unsigned IRQ_EXT      = 1;
    localparam int unsigned IRQ_TMR      = 2;
    localparam logic [2:0]  IRQ_WAKE_MSK = 3'h3;
    localparam int unsigned OST_TOSC     = 1024;
    localparam int unsigned OST_CYCLES   = OST_TOSC;
    localparam int unsigned WDT_US       = 18_000;
    localparam int unsigned WDT_CYCLES   = WDT_US * (CLK_HZ / 1_000_000);
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [3:0] {
        S_RUN    = 4'h1,
        S_SLEEP  = 4'h2,
        S_START  = 4'h4,
        S_RESUME = 4'h8
    } pdwc_state_type;
endpackage : pdwc_pkg

// [hdl/pdwc_sync.sv]
/*
 * pdwc_sync: two flip-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pdwc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } pdwc_sync_type;

    pdwc_sync_type q_ff;
    pdwc_sync_type nxt_q;

    always_comb begin
        nxt_q    = q_ff;
        nxt_q.s1 = pin_i;
        nxt_q.s2 = q_ff.s1;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_ff <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign level_o = q_ff.s2;
endmodule : pdwc_sync
`default_nettype wire

// [hdl/pdwc_top.sv]
/*
 * pdwc_top: power-down and wake controller of a small core.
 * assumes the core gives one-cycle pulses when it executes the
 * power-down or watchdog-clear instruction, and its interrupt flags
 * and enables on the same clock; the reset pin is asynchronous.
 */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdwc_top #(
    parameter int unsigned WDT_CYCLES = pdwc_pkg::WDT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [15:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [7:0]  config_word_i,
    input  wire logic        master_clear_pin_i,
    input  wire logic        sleep_exec_i,
    input  wire logic        watchdog_clear_instruction_i,
    input  wire logic [2:0]  irq_flag_i,
    input  wire logic [2:0]  irq_en_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic [7:0]  port_out_i,
    input  wire logic [7:0]  port_oe_i,
    output logic [7:0]       port_out_o,
    output logic [7:0]       port_oe_o,
    output logic             osc_drive_en_o,
    output logic             core_reset_o,
    output logic             prefetch_next_o,
    output logic             resume_o,
    output logic             vector_irq_o,
    output logic             timer_stop_o,
    output logic             powered_down_flag_o,
    output logic             timeout_flag_o
);
    typedef struct packed {
        pdwc_pkg::pdwc_state_type st;
        logic                     dn;
        logic                     to;
        logic [7:0]               opt;
        logic [7:0]               cfg;
        logic                     cfg_ld;
        logic [10:0]              ost;
        logic [7:0]               pout;
        logic [7:0]               poe;
        logic                     rst_out;
        logic                     irq_wake;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } pdwc_top_type;

    localparam logic [10:0] OST_LAST = 11'(pdwc_pkg::OST_CYCLES - 1);

    pdwc_top_type q_ff;
    pdwc_top_type nxt_q;
    logic         mc_lvl;
    logic         mc_low;
    logic         wdt_to;
    logic         wdt_en;
    logic         wdt_clr;
    logic         wake_irq;
    logic         rc_mode;
    logic         aw_go;
    logic         ar_go;
    logic [33:0]  rd;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // address decode shared by the read path; unmapped gives slverr
    function automatic logic [33:0] reg_read(
        input logic [15:0] addr,
        input logic [7:0]  opt,
        input logic [7:0]  cfg,
        input logic [7:0]  stat
    );
        logic [33:0] r;
        r = {pdwc_pkg::RESP_SLVERR, 32'h0000_0000};
        case (addr)
            pdwc_pkg::OPTION_ADDR: r = {pdwc_pkg::RESP_OKAY, 24'h0, opt};
            pdwc_pkg::CONFIG_ADDR: r = {pdwc_pkg::RESP_OKAY, 24'h0, cfg};
            pdwc_pkg::STATUS_ADDR: r = {pdwc_pkg::RESP_OKAY, 24'h0, stat};
            pdwc_pkg::CONTROL_ADDR: r = {pdwc_pkg::RESP_OKAY, 32'h0};
            default: r = {pdwc_pkg::RESP_SLVERR, 32'h0000_0000};
        endcase
        return r;
    endfunction : reg_read

    pdwc_sync #(
        .RST_VAL (1'b1)
    ) u_mc_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (master_clear_pin_i),
        .level_o   (mc_lvl)
    );

    pdwc_wdt #(
        .BASE_CYCLES (WDT_CYCLES)
    ) u_wdt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .enable_i  (wdt_en),
        .clear_i   (wdt_clr),
        .post_sel_i (q_ff.opt[pdwc_pkg::OPT_POST_SEL]),
        .ps_i      (q_ff.opt[pdwc_pkg::OPT_PS_LSB +: 3]),
        .timeout_o (wdt_to)
    );

    assign mc_low   = !mc_lvl;
    assign wdt_en   = q_ff.cfg_ld && q_ff.cfg[pdwc_pkg::CFG_WD_EN];
    assign rc_mode  = q_ff.cfg[pdwc_pkg::CFG_OSC_LSB +: 2]
                      == pdwc_pkg::OSC_MODE_RC;
    // timer flag is masked: the timer is frozen while asleep
    assign wake_irq = |(irq_flag_i & irq_en_i
                        & pdwc_pkg::IRQ_WAKE_MSK);
    assign aw_go    = s_axi_awvalid_i && s_axi_wvalid_i && !q_ff.bvalid;
    assign ar_go    = s_axi_arvalid_i && !q_ff.rvalid;
    assign rd       = reg_read(s_axi_araddr_i, q_ff.opt, q_ff.cfg,
                               {5'h00,
                                q_ff.st == pdwc_pkg::S_SLEEP,
                                q_ff.to, q_ff.dn});

    always_comb begin
        nxt_q         = q_ff;
        nxt_q.rst_out = 1'b0;
        wdt_clr       = 1'b0;
        // strap is caught once, on the first edge after reset release
        if (!q_ff.cfg_ld) begin
            nxt_q.cfg    = config_word_i;
            nxt_q.cfg_ld = 1'b1;
        end
        case (q_ff.st)
            pdwc_pkg::S_RUN: begin
                nxt_q.pout = port_out_i;
                nxt_q.poe  = port_oe_i;
                if (watchdog_clear_instruction_i) begin
                    wdt_clr = 1'b1;
                end
                if (sleep_exec_i) begin
                    nxt_q.st   = pdwc_pkg::S_SLEEP;
                    nxt_q.pout = q_ff.pout;
                    nxt_q.poe  = q_ff.poe;
                    nxt_q.dn   = 1'b0;
                    nxt_q.to   = 1'b1;
                    wdt_clr    = 1'b1;
                end else if (wdt_to) begin
                    // internal reset only; the reset pin is never driven
                    nxt_q.rst_out = 1'b1;
                    nxt_q.to      = 1'b0;
                end
            end
            pdwc_pkg::S_SLEEP: begin
                // evaluated every cycle, so an irq already pending at
                // entry wakes on the very next cycle
                if ((wdt_to && wdt_en) || wake_irq) begin
                    wdt_clr        = 1'b1;
                    nxt_q.irq_wake = !(wdt_to && wdt_en);
                    nxt_q.ost      = 11'h000;
                    if (wdt_to && wdt_en) begin
                        nxt_q.to = 1'b0;
                    end
                    if (rc_mode) begin
                        nxt_q.st = pdwc_pkg::S_RESUME;
                    end else begin
                        nxt_q.st = pdwc_pkg::S_START;
                    end
                end
            end
            pdwc_pkg::S_START: begin
                nxt_q.ost = q_ff.ost + 11'h001;
                if (q_ff.ost == OST_LAST) begin
                    nxt_q.st = pdwc_pkg::S_RESUME;
                end
            end
            pdwc_pkg::S_RESUME: begin
                nxt_q.st = pdwc_pkg::S_RUN;
            end
            default: begin
                nxt_q.st = pdwc_pkg::S_RUN;
            end
        endcase
        // master clear wins over the next state, watchdog clear and reset output: a full core reset
        if (mc_low) begin
            nxt_q.st      = pdwc_pkg::S_RUN;
            nxt_q.rst_out = 1'b1;
            wdt_clr       = 1'b1;
        end
        // register bus: address and data are taken together
        if (aw_go) begin
            nxt_q.bvalid = 1'b1;
            nxt_q.bresp  = pdwc_pkg::RESP_OKAY;
            case (s_axi_awaddr_i)
                pdwc_pkg::OPTION_ADDR: begin
                    if (s_axi_wstrb_i[0]) begin
                        nxt_q.opt = s_axi_wdata_i[7:0];
                    end
                end
                pdwc_pkg::CONTROL_ADDR: begin
                    // software-visible power-on marker: set pd and to
                    if (s_axi_wstrb_i[0]
                        && s_axi_wdata_i[pdwc_pkg::CTL_PORST]) begin
                        nxt_q.dn = 1'b1;
                        nxt_q.to = 1'b1;
                    end
                end
                default: begin
                    nxt_q.bresp = pdwc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q_ff.bvalid && s_axi_bready_i) begin
            nxt_q.bvalid = 1'b0;
        end
        if (ar_go) begin
            nxt_q.rvalid = 1'b1;
            nxt_q.rresp  = rd[33:32];
            nxt_q.rdata  = rd[31:0];
        end else if (q_ff.rvalid && s_axi_rready_i) begin
            nxt_q.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_ff     <= '0;
            q_ff.st  <= pdwc_pkg::S_RUN;
            q_ff.dn  <= 1'b1;
            q_ff.to  <= 1'b1;
            q_ff.opt <= pdwc_pkg::OPTION_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign s_axi_awready_o     = aw_go;
    assign s_axi_wready_o      = aw_go;
    assign s_axi_bvalid_o      = q_ff.bvalid;
    assign s_axi_bresp_o       = q_ff.bresp;
    assign s_axi_arready_o     = !q_ff.rvalid;
    assign s_axi_rvalid_o      = q_ff.rvalid;
    assign s_axi_rdata_o       = q_ff.rdata;
    assign s_axi_rresp_o       = q_ff.rresp;
    assign port_out_o          = q_ff.pout;
    assign port_oe_o           = q_ff.poe;
    assign osc_drive_en_o      = q_ff.st != pdwc_pkg::S_SLEEP;
    assign core_reset_o        = q_ff.rst_out;
    assign prefetch_next_o     = sleep_exec_i
                                 && q_ff.st == pdwc_pkg::S_RUN;
    assign resume_o            = q_ff.st == pdwc_pkg::S_RESUME;
    assign vector_irq_o        = resume_o && q_ff.irq_wake
                                 && global_irq_enable_i;
    assign timer_stop_o        = q_ff.st != pdwc_pkg::S_RUN;
    assign powered_down_flag_o = q_ff.dn;
    assign timeout_flag_o      = q_ff.to;

    a_sleep_entry_flags: assert property (
        q_ff.st == pdwc_pkg::S_RUN && sleep_exec_i && !mc_low
        |=> q_ff.st == pdwc_pkg::S_SLEEP && !q_ff.dn && q_ff.to
            && !osc_drive_en_o)
        else $error("power-down entry did not update flags");

    a_sleep_only_instr: assert property (
        $rose(q_ff.st == pdwc_pkg::S_SLEEP) |-> $past(sleep_exec_i))
        else $error("power-down entered without the instruction");

    a_port_hold_sleep: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP ##1 q_ff.st == pdwc_pkg::S_SLEEP
        |-> $stable(port_out_o) && $stable(port_oe_o))
        else $error("port drive changed while powered down");

    a_wdt_run_reset: assert property (
        q_ff.st == pdwc_pkg::S_RUN && wdt_to && !sleep_exec_i
        |=> core_reset_o && !timeout_flag_o)
        else $error("running watchdog timeout did not reset");

    a_wdt_wake_flag: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP && wdt_to && wdt_en && !mc_low
        |=> !timeout_flag_o && !core_reset_o
            && q_ff.st != pdwc_pkg::S_SLEEP)
        else $error("watchdog wake did not clear timeout flag");

    a_irq_wake_go: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP && wake_irq && !mc_low
        |=> !core_reset_o && (q_ff.st == pdwc_pkg::S_START
                              || q_ff.st == pdwc_pkg::S_RESUME))
        else $error("enabled interrupt did not wake the core");

    a_timer_no_wake: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP && !mc_low && !wdt_to
        && (irq_flag_i & irq_en_i) == 3'h4
        |=> q_ff.st == pdwc_pkg::S_SLEEP)
        else $error("timer overflow woke the core");

    a_ost_full_wait: assert property (
        $fell(q_ff.st == pdwc_pkg::S_START) && !$past(mc_low)
        |-> $past(q_ff.ost) == OST_LAST)
        else $error("start-up wait was not 1024 cycles");

    a_rc_no_wait: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP && rc_mode && wake_irq && !mc_low
        |=> resume_o)
        else $error("rc mode waited for oscillator start-up");

    a_wake_wdt_clear: assert property (
        q_ff.st == pdwc_pkg::S_SLEEP
        && ((wdt_to && wdt_en) || wake_irq)
        |=> u_wdt.q_ff.base == '0 && u_wdt.q_ff.post == 8'h00)
        else $error("wake did not clear the watchdog");

    a_vector_gated: assert property (
        vector_irq_o |-> timeout_flag_o && !core_reset_o
                         && global_irq_enable_i)
        else $error("vector taken without an interrupt wake");

    a_wdt_off_quiet: assert property (
        !wdt_en && $past(!wdt_en) |-> !wdt_to)
        else $error("disabled watchdog timed out");

    // counted apart from the start-up counter so a broken one shows
    logic [10:0] start_len_ff;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || q_ff.st != pdwc_pkg::S_START) begin
            start_len_ff <= 11'h000;
        end else begin
            start_len_ff <= start_len_ff + 11'h001;
        end
    end

    a_ost_bounded: assert property (
        q_ff.st == pdwc_pkg::S_START
        |-> start_len_ff < 11'(pdwc_pkg::OST_CYCLES))
        else $error("start-up wait ran past its length");
endmodule : pdwc_top
`default_nettype wire

// [hdl/pdwc_wdt.sv]
/*
 * pdwc_wdt: watchdog base counter with its shared postscaler.
 * assumes clear and enable come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pdwc_wdt #(
    parameter int unsigned BASE_CYCLES = pdwc_pkg::WDT_CYCLES,
    parameter int unsigned CNT_W       = 20
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       enable_i,
    input  wire logic       clear_i,
    input  wire logic       post_sel_i,
    input  wire logic [2:0] ps_i,
    output logic            timeout_o
);
    typedef struct packed {
        logic [CNT_W-1:0] base;
        logic [7:0]       post;
        logic             to;
    } pdwc_wdt_type;

    localparam logic [CNT_W-1:0] BASE_LAST = CNT_W'(BASE_CYCLES - 1);

    pdwc_wdt_type q_ff;
    pdwc_wdt_type nxt_q;
    logic [7:0]   post_last;

    always_comb begin
        nxt_q     = q_ff;
        nxt_q.to  = 1'b0;
        post_last = 8'((9'h001 << ps_i) - 9'h001);
        if (clear_i || !enable_i) begin
            nxt_q.base = '0;
            nxt_q.post = '0;
        end else if (q_ff.base == BASE_LAST) begin
            nxt_q.base = '0;
            if (!post_sel_i || q_ff.post == post_last) begin
                nxt_q.post = '0;
                nxt_q.to   = 1'b1;
            end else begin
                nxt_q.post = q_ff.post + 8'h01;
            end
        end else begin
            nxt_q.base = q_ff.base + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign timeout_o = q_ff.to;
endmodule : pdwc_wdt
`default_nettype wire
